// File: verilog/msg_obj_map.svh
// Register offsets, field positions, reset values and mode codes of the
// message object block. Assumes inclusion by bare name from the module only.
`ifndef MSG_OBJ_MAP_SVH
`define MSG_OBJ_MAP_SVH

// Word select inside one object's four-word group
`define MO_CTRL        2'h0
`define MO_FUNC        2'h1
`define MO_PTR         2'h2
`define MO_LIST        2'h3

// Control word bits
`define CTRL_VALID     0
`define CTRL_FRESH     1
`define CTRL_LOST      2
`define CTRL_SEND      3
`define CTRL_RECEIVE_ACCEPT_ENABLE      4

// Function word fields
`define FUNC_MODE_LO   0
`define FUNC_MODE_HI   3
`define FUNC_SDT       4
`define FUNC_STT       5
`define FUNC_FIFO_WRAP_IRQ_ENABLE      6
`define FUNC_SEND_IRQ_ENABLE      7
`define FUNC_LINE_LO   8
`define FUNC_LINE_HI   11

// Pointer word fields, one byte each
`define PTR_LOWER_LO   0
`define PTR_UPPER_LO   8
`define PTR_ACTIVE_LO  16
`define PTR_WATCH_LO   24

// Mode codes
`define MODE_STD       4'h0
`define MODE_RXFIFO    4'h1

// Reset values
`define RST_FLAGS      1'b0
`define RST_MODE       4'h0
`define RST_LINE       4'h0

`endif

// File: verilog/msg_obj_pkg.sv
// Types shared by the message object block and its surroundings.
// Assumes at most 256 message objects, so an index fits one byte.
package msg_obj_pkg;

  typedef logic [7:0] obj_idx_t;

  // Frame event from the node engine (stored, copied or sent) for an object that won filtering
  typedef struct packed {
    logic     valid;
    obj_idx_t obj;
    logic     remote;
  } frame_evt_s;

  // Result of a delivery: where the frame finally went
  typedef struct packed {
    logic     valid;
    obj_idx_t obj;
  } store_evt_s;

endpackage

// File: verilog/msg_obj_modes.sv
// Per-object mode logic: standard mode, single delivery, one-shot send,
// circular FIFO pointers and receive FIFO redirection.
// Assumes the node engine on the same clock, one pulse per event.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "msg_obj_map.svh"

module msg_obj_modes
  import msg_obj_pkg::*;
#(
  parameter int NUM_OBJ = 32
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port: {object, word} address
  input  wire logic [9:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [31:0] rdata,
  // Node frame engine
  input  wire frame_evt_s rx_evt,
  input  wire frame_evt_s tx_copy_evt,
  input  wire frame_evt_s tx_done_evt,
  output store_evt_s      store_evt,
  // Interrupt request lines, one-cycle pulses
  output logic      [15:0] irq_lines
);

  localparam int IW = (NUM_OBJ > 1) ? $clog2(NUM_OBJ) : 1;
  typedef logic [IW-1:0] idx_t;

  // Per-object state
  logic [NUM_OBJ-1:0] valid_r, fresh_r, lost_r, send_r, receive_accept_enable_r;
  logic [NUM_OBJ-1:0] sdt_r, stt_r, fifo_wrap_irq_enable_r, send_irq_enable_r;
  logic [3:0]         mode_r  [NUM_OBJ];
  logic [3:0]         line_r  [NUM_OBJ];
  idx_t               lower_r [NUM_OBJ];
  idx_t               upper_r [NUM_OBJ];
  idx_t               active_r[NUM_OBJ];
  idx_t               watch_r [NUM_OBJ];
  idx_t               succ_r  [NUM_OBJ];

  // Indexes beyond the object count are dropped, never aliased
  function automatic logic in_range(input obj_idx_t o);
    return 32'(o) < NUM_OBJ;
  endfunction

  // Receive path decode
  logic rx_ok, rx_fifo, do_store, irq_wrap;
  idx_t base, dest, act_nxt;
  always_comb begin
    rx_ok    = rx_evt.valid && in_range(rx_evt.obj);
    base     = rx_evt.obj[IW-1:0];
    rx_fifo  = rx_ok && (mode_r[base] == `MODE_RXFIFO);
    dest     = rx_fifo ? active_r[base] : base;
    // Slave mode and identifier are not consulted here
    do_store = rx_ok && valid_r[base] && valid_r[dest];
    act_nxt  = (active_r[base] == upper_r[base]) ?
               lower_r[base] : succ_r[active_r[base]];
    irq_wrap = rx_fifo && do_store && fifo_wrap_irq_enable_r[base] &&
               (act_nxt == watch_r[base]);
  end

  logic cp_ok, dn_ok;
  idx_t cobj, dobj;
  assign cp_ok = tx_copy_evt.valid && in_range(tx_copy_evt.obj);
  assign dn_ok = tx_done_evt.valid && in_range(tx_done_evt.obj);
  assign cobj  = tx_copy_evt.obj[IW-1:0];
  assign dobj  = tx_done_evt.obj[IW-1:0];

  logic [1:0] wsel;
  logic       wobj_ok;
  idx_t       wobj;
  assign wsel    = addr[1:0];
  assign wobj_ok = in_range(addr[9:2]);
  assign wobj    = addr[IW+1:2];

  // Pointers are plain registers, so reconfiguring any time is safe
  for (genvar i = 0; i < NUM_OBJ; i++) begin : g_obj
    logic we;
    assign we = wr && wobj_ok && (wobj == idx_t'(i));

    // Status flags; engine events come after the write so an engine set or clear wins
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        valid_r[i] <= `RST_FLAGS;
        fresh_r[i] <= `RST_FLAGS;
        lost_r[i]  <= `RST_FLAGS;
        send_r[i]  <= `RST_FLAGS;
        receive_accept_enable_r[i]  <= `RST_FLAGS;
      end else begin
        if (we && wsel == `MO_CTRL) begin
          valid_r[i] <= wdata[`CTRL_VALID];
          fresh_r[i] <= wdata[`CTRL_FRESH];
          lost_r[i]  <= wdata[`CTRL_LOST];
          send_r[i]  <= wdata[`CTRL_SEND];
          receive_accept_enable_r[i]  <= wdata[`CTRL_RECEIVE_ACCEPT_ENABLE];
        end
        if (cp_ok && cobj == idx_t'(i)) begin
          fresh_r[i] <= 1'b0;
          if (stt_r[i])
            send_r[i] <= 1'b0;
        end
        if (dn_ok && dobj == idx_t'(i)) begin
          if (!fresh_r[i])
            send_r[i] <= 1'b0;
          if (sdt_r[i] && !tx_done_evt.remote)
            valid_r[i] <= 1'b0;
        end
        if (do_store && dest == idx_t'(i)) begin
          fresh_r[i] <= 1'b1;
          if (fresh_r[i])
            lost_r[i] <= 1'b1;
          if (rx_evt.remote)
            send_r[i] <= 1'b1;
          else if (sdt_r[i])
            valid_r[i] <= 1'b0;
        end
      end
    end

    // Function word
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        mode_r[i] <= `RST_MODE;
        sdt_r[i]  <= `RST_FLAGS;
        stt_r[i]  <= `RST_FLAGS;
        fifo_wrap_irq_enable_r[i] <= `RST_FLAGS;
        send_irq_enable_r[i] <= `RST_FLAGS;
        line_r[i] <= `RST_LINE;
      end else if (we && wsel == `MO_FUNC) begin
        mode_r[i] <= wdata[`FUNC_MODE_HI:`FUNC_MODE_LO];
        sdt_r[i]  <= wdata[`FUNC_SDT];
        stt_r[i]  <= wdata[`FUNC_STT];
        fifo_wrap_irq_enable_r[i] <= wdata[`FUNC_FIFO_WRAP_IRQ_ENABLE];
        send_irq_enable_r[i] <= wdata[`FUNC_SEND_IRQ_ENABLE];
        line_r[i] <= wdata[`FUNC_LINE_HI:`FUNC_LINE_LO];
      end
    end

    // FIFO pointers; advance after store beats a software write
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        lower_r[i]  <= '0;
        upper_r[i]  <= '0;
        active_r[i] <= '0;
        watch_r[i]  <= '0;
        succ_r[i]   <= '0;
      end else begin
        if (we && wsel == `MO_PTR) begin
          lower_r[i]  <= wdata[`PTR_LOWER_LO +: IW];
          upper_r[i]  <= wdata[`PTR_UPPER_LO +: IW];
          active_r[i] <= wdata[`PTR_ACTIVE_LO +: IW];
          watch_r[i]  <= wdata[`PTR_WATCH_LO +: IW];
        end
        if (we && wsel == `MO_LIST)
          succ_r[i] <= wdata[IW-1:0];
        if (rx_fifo && do_store && base == idx_t'(i))
          active_r[i] <= act_nxt;
      end
    end
  end

  // Interrupt pulses
  logic [15:0] irq_nxt;
  always_comb begin
    irq_nxt = '0;
    if (irq_wrap)
      irq_nxt[line_r[base]] = 1'b1;
    if (dn_ok && send_irq_enable_r[dobj])
      irq_nxt[line_r[dobj]] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_lines <= '0;
      store_evt <= '0;
    end else begin
      irq_lines       <= irq_nxt;
      store_evt.valid <= do_store;
      store_evt.obj   <= obj_idx_t'(dest);
    end
  end

  // Read data, valid only in the cycle after a read strobe
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    if (rd && wobj_ok) begin
      unique case (wsel)
        `MO_CTRL: begin
          rd_nxt[`CTRL_VALID] = valid_r[wobj];
          rd_nxt[`CTRL_FRESH] = fresh_r[wobj];
          rd_nxt[`CTRL_LOST]  = lost_r[wobj];
          rd_nxt[`CTRL_SEND]  = send_r[wobj];
          rd_nxt[`CTRL_RECEIVE_ACCEPT_ENABLE]  = receive_accept_enable_r[wobj];
        end
        `MO_FUNC: begin
          rd_nxt[`FUNC_MODE_HI:`FUNC_MODE_LO] = mode_r[wobj];
          rd_nxt[`FUNC_SDT]  = sdt_r[wobj];
          rd_nxt[`FUNC_STT]  = stt_r[wobj];
          rd_nxt[`FUNC_FIFO_WRAP_IRQ_ENABLE] = fifo_wrap_irq_enable_r[wobj];
          rd_nxt[`FUNC_SEND_IRQ_ENABLE] = send_irq_enable_r[wobj];
          rd_nxt[`FUNC_LINE_HI:`FUNC_LINE_LO] = line_r[wobj];
        end
        `MO_PTR: begin
          rd_nxt[`PTR_LOWER_LO +: IW]  = lower_r[wobj];
          rd_nxt[`PTR_UPPER_LO +: IW]  = upper_r[wobj];
          rd_nxt[`PTR_ACTIVE_LO +: IW] = active_r[wobj];
          rd_nxt[`PTR_WATCH_LO +: IW]  = watch_r[wobj];
        end
        `MO_LIST: rd_nxt[IW-1:0] = succ_r[wobj];
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rdata <= '0;
    else
      rdata <= rd_nxt;
  end

endmodule // msg_obj_modes

// File: dv/msg_obj_engine.sv
// Node frame engine model: fires stored-frame, copy and sent events.
// Assumes the block samples each event on one rising edge.
`timescale 1ns/1ps
module msg_obj_engine import msg_obj_pkg::*; (
  // Clock
  input  wire logic clk,
  // Events toward the block
  output frame_evt_s rx_evt,
  output frame_evt_s tx_copy_evt,
  output frame_evt_s tx_done_evt
);
  initial begin
    rx_evt = '0;
    tx_copy_evt = '0;
    tx_done_evt = '0;
  end
  // Names the filter winner only, never matched against slaves
  task automatic fire(input int k, input int o, input logic r);
    frame_evt_s e;
    e = {1'b1, 8'(o), r};
    @(posedge clk);
    if (k == 0) rx_evt <= e;
    else if (k == 1) tx_copy_evt <= e;
    else tx_done_evt <= e;
    @(posedge clk);
    rx_evt <= '0;
    tx_copy_evt <= '0;
    tx_done_evt <= '0;
    #1;
  endtask
endmodule // msg_obj_engine

// File: dv/msg_obj_modes_monitor.sv
// Port checker of the message object block, bound to its top module.
// Assumes one-cycle event pulses and read data one cycle late.
`timescale 1ns/1ps
module msg_obj_modes_monitor import msg_obj_pkg::*; #(
  parameter int NUM_OBJ = 32
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register port
  input wire logic [9:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Engine side
  input wire frame_evt_s  rx_evt,
  input wire frame_evt_s  tx_copy_evt,
  input wire frame_evt_s  tx_done_evt,
  input wire store_evt_s  store_evt,
  input wire logic [15:0] irq_lines
);
  localparam int IW = (NUM_OBJ > 1) ? $clog2(NUM_OBJ) : 1;
  localparam logic [31:0] PMASK = {4{8'((1 << IW) - 1)}};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  store_cause_a: assert property (store_evt.valid |-> $past(rx_evt.valid))
    else $error("store without frame");
  store_range_a: assert property (store_evt.valid |-> store_evt.obj < NUM_OBJ)
    else $error("store to missing object");
  irq_cause_a: assert property (|irq_lines |-> $past(rx_evt.valid || tx_done_evt.valid))
    else $error("interrupt without event");
  copy_quiet_a: assert property (
    tx_copy_evt.valid && !(rx_evt.valid || tx_done_evt.valid) |=> irq_lines == 16'h0)
    else $error("interrupt after copy");
  read_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  ptr_width_a: assert property (rd && addr[1:0] == 2'h2 |=> (rdata & ~PMASK) == 32'h0)
    else $error("pointer field too wide");
  ctrl_bits_a: assert property (rd && addr[1:0] == 2'h0 |=> rdata[31:5] == 27'h0)
    else $error("control word spare bits set");
  oob_read_a: assert property (rd && addr[9:2] >= NUM_OBJ |=> rdata == 32'h0)
    else $error("missing object reads nonzero");
endmodule // msg_obj_modes_monitor

bind msg_obj_modes msg_obj_modes_monitor #(.NUM_OBJ(NUM_OBJ)) msg_obj_modes_monitor_inst (
  .clk(clk), .nrst(nrst), .addr(addr), .rd(rd), .rdata(rdata), .rx_evt(rx_evt),
  .tx_copy_evt(tx_copy_evt), .tx_done_evt(tx_done_evt), .store_evt(store_evt),
  .irq_lines(irq_lines));

// File: dv/msg_obj_modes_tb_top.sv
// Self-checking bench of the message object block with an engine model.
// Assumes eight objects, so pointer fields use three bits.
`timescale 1ns/1ps
module msg_obj_modes_tb_top import msg_obj_pkg::*;;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [9:0]  addr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  frame_evt_s  rx_evt, tx_copy_evt, tx_done_evt;
  store_evt_s  store_evt;
  logic [15:0] irq_lines;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #5 clk = ~clk;
  msg_obj_modes #(.NUM_OBJ(8)) msg_obj_modes_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_evt(rx_evt),
    .tx_copy_evt(tx_copy_evt), .tx_done_evt(tx_done_evt), .store_evt(store_evt),
    .irq_lines(irq_lines));
  msg_obj_engine msg_obj_engine_inst (.clk(clk), .rx_evt(rx_evt),
    .tx_copy_evt(tx_copy_evt), .tx_done_evt(tx_done_evt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input int o, input int w, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= {8'(o), 2'(w)};
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input int o, input int w, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= {8'(o), 2'(w)};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Destination -1 means no store expected
  task automatic evt(input int k, input int o, input logic r, input int d, input int q);
    msg_obj_engine_inst.fire(k, o, r);
    // Object field only means something on a stored frame
    chk({31'h0, store_evt.valid}, {31'h0, d >= 0});
    if (d >= 0) chk({24'h0, store_evt.obj}, 32'(d));
    chk({16'h0, irq_lines}, 32'(q));
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset;
    for (int w = 0; w < 4; w++) rreg(3, w, 32'h0);
    wreg(8, 0, 32'h1F);
    rreg(8, 0, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_std;
    wreg(1, 0, 32'h1);
    evt(0, 1, 1'b0, 1, 0);
    evt(0, 1, 1'b0, 1, 0);
    rreg(1, 0, 32'h7);
    wreg(1, 1, 32'h380);
    evt(2, 1, 1'b0, -1, 32'h8);
    $display("standard test done");
  endtask
  task automatic t_single;
    wreg(2, 1, 32'h10);
    wreg(2, 0, 32'h1);
    evt(0, 2, 1'b1, 2, 0);
    rreg(2, 0, 32'hB);
    evt(0, 2, 1'b0, 2, 0);
    rreg(2, 0, 32'hE);
    evt(0, 2, 1'b0, -1, 0);
    wreg(3, 1, 32'h10);
    wreg(3, 0, 32'h9);
    evt(2, 3, 1'b1, -1, 0);
    rreg(3, 0, 32'h1);
    evt(2, 3, 1'b0, -1, 0);
    rreg(3, 0, 32'h0);
    $display("single delivery test done");
  endtask
  task automatic t_oneshot;
    wreg(4, 1, 32'h20);
    wreg(4, 0, 32'hB);
    evt(1, 4, 1'b0, -1, 0);
    rreg(4, 0, 32'h1);
    wreg(5, 0, 32'h9);
    evt(1, 5, 1'b0, -1, 0);
    rreg(5, 0, 32'h9);
    $display("one-shot test done");
  endtask
  task automatic t_fifo;
    for (int i = 5; i < 8; i++) wreg(i, 0, 32'h1); // No direct accept
    wreg(6, 1, 32'h1);
    wreg(5, 3, 32'h6);
    wreg(6, 3, 32'h7);
    wreg(0, 2, 32'h07050705);
    wreg(0, 1, 32'h541);
    wreg(0, 0, 32'h1);
    for (int i = 0; i < 3; i++) evt(0, 0, 1'b0, 5 + i, (i == 1) ? 32'h20 : 0);
    rreg(0, 2, 32'h07050705);
    rreg(0, 0, 32'h1);
    rreg(6, 0, 32'h3);
    wreg(5, 0, 32'h0);
    evt(0, 0, 1'b0, -1, 0);
    rreg(0, 2, 32'h07050705);
    wreg(0, 2, 32'h0); // Base becomes its own only slave
    evt(0, 0, 1'b0, 0, 32'h20);
    rreg(0, 0, 32'h3);
    $display("fifo test done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_std();
    t_single();
    t_oneshot();
    t_fifo();
    end_sim();
  end
endmodule // msg_obj_modes_tb_top
